// >>> asc_pkg.sv
package asc_pkg;
	localparam logic [2:0] DEPTH = 3'h4;
	localparam logic [2:0] ADDR_BANK = 3'h2;
	localparam logic [4:0] IDX_DATA0 = 5'h00;
	localparam logic [4:0] IDX_GEN_EN = 5'h01;
	localparam logic [4:0] IDX_LINE_CTL = 5'h03;
	localparam logic [4:0] IDX_MDM_CTL = 5'h04;
	localparam logic [4:0] IDX_LINE_ST = 5'h05;
	localparam logic [4:0] IDX_MDM_ST = 5'h06;
	localparam logic [4:0] IDX_MATCH0 = 5'h07;
	localparam logic [4:0] IDX_DATA1 = 5'h08;
	localparam logic [4:0] IDX_CHFLAG = 5'h09;
	localparam logic [4:0] IDX_TIMER = 5'h0b;
	localparam logic [4:0] IDX_LEVEL = 5'h0c;
	localparam logic [4:0] IDX_RX_CMD = 5'h0d;
	localparam logic [4:0] IDX_TX_CMD = 5'h0e;
	localparam logic [4:0] IDX_INT_CMD = 5'h0f;
	localparam logic [4:0] IDX_FIFO_MODE = 5'h11;
	localparam logic [4:0] IDX_TX_MODE = 5'h13;
	localparam logic [4:0] IDX_INT_MODE = 5'h14;
	localparam logic [4:0] IDX_MATCH1 = 5'h15;
	localparam logic [4:0] IDX_RX_IE = 5'h16;
	localparam logic [4:0] IDX_RX_MODE = 5'h17;
	localparam logic [4:0] IDX_CLK_SRC = 5'h18;
	localparam logic [4:0] IDX_BAUD_A_CFG = 5'h19;
	localparam logic [4:0] IDX_BAUD_B_CFG = 5'h1b;
	localparam logic [4:0] IDX_PIN_MODE = 5'h1c;
	localparam logic [4:0] IDX_MDM_IE = 5'h1d;
	localparam logic [4:0] IDX_TXM_IE = 5'h1e;
	localparam logic [7:0] RV_ZERO = 8'h00;
	localparam logic [7:0] RV_INT_MODE = 8'h0c;
	localparam logic [7:0] RV_RX_IE = 8'h1e;
	localparam logic [7:0] RV_BAUD_A_CFG = 8'h04;
	localparam logic [7:0] RV_BAUD_B_CFG = 8'h84;
	localparam logic [7:0] RV_PIN_MODE = 8'hfc;
	localparam logic [7:0] RV_MDM_IE = 8'h0f;
	localparam logic [7:0] RV_DIV_A_LO = 8'h02;
	localparam logic [7:0] RV_DIV_B_LO = 8'h05;
	localparam logic [7:0] TIMER_ST_RV = 8'h30;
	localparam int LC_LEN = 0;
	localparam int LC_STOP = 2;
	localparam int LC_PAR_EN = 3;
	localparam int LC_PAR_EVEN = 4;
	localparam int LC_LATCH = 7;
	localparam int LS_RX_RDY = 0;
	localparam int LS_OVR = 1;
	localparam int LS_PERR = 2;
	localparam int LS_FERR = 3;
	localparam int LS_TX_EMPTY = 5;
	localparam int LS_TX_IDLE = 6;
	localparam int GS_RX = 0;
	localparam int GS_TX_ROOM = 1;
	localparam int GS_TX_IDLE = 4;
	localparam int GI_NONE = 0;
	localparam int GI_SRC = 1;
	localparam int BANK_POS = 5;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_LOOP = 4;
	localparam int MS_DCTS = 0;
	localparam int MS_CTS = 4;
	localparam int FM_TXD = 0;
	localparam int FM_RXD = 2;
	localparam int TM_FLOW = 0;
	localparam int RM_ADDR = 0;
	localparam int RM_CTRL = 1;
	localparam int CK_TXB = 0;
	localparam int CK_RXB = 1;
	localparam int CMD_FLUSH = 0;
	localparam int GE_RX = 0;
	localparam int GE_TX = 1;
	localparam int GE_LINE = 2;
	localparam int GE_MDM = 3;
	localparam int FL_TX = 0;
	localparam int FL_RX = 4;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] data;
	} asc_req_t;
	typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} asc_tx_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
	} asc_rx_t;
	function automatic logic cfg_kept(input logic [4:0] idx);
		case (idx)
			IDX_GEN_EN, IDX_LINE_CTL, IDX_MDM_CTL, IDX_MATCH0, IDX_FIFO_MODE,
			IDX_TX_MODE, IDX_INT_MODE, IDX_MATCH1, IDX_RX_IE, IDX_RX_MODE,
			IDX_CLK_SRC, IDX_BAUD_A_CFG, IDX_BAUD_B_CFG, IDX_PIN_MODE,
			IDX_MDM_IE, IDX_TXM_IE: cfg_kept = 1'b1;
			default: cfg_kept = 1'b0;
		endcase
	endfunction
	function automatic logic [7:0] cfg_reset(input logic [4:0] idx);
		case (idx)
			IDX_INT_MODE: cfg_reset = RV_INT_MODE;
			IDX_RX_IE: cfg_reset = RV_RX_IE;
			IDX_BAUD_A_CFG: cfg_reset = RV_BAUD_A_CFG;
			IDX_BAUD_B_CFG: cfg_reset = RV_BAUD_B_CFG;
			IDX_PIN_MODE: cfg_reset = RV_PIN_MODE;
			IDX_MDM_IE: cfg_reset = RV_MDM_IE;
			default: cfg_reset = RV_ZERO;
		endcase
	endfunction
endpackage

// >>> asc_top.sv
`timescale 1ns/100ps
module asc_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Host port
	input wire logic chip_select_low,
	input wire logic read_strobe_low,
	input wire logic write_strobe_low,
	input wire logic [2:0] register_address_lines,
	input wire logic [7:0] host_data_lines_in,
	output logic [7:0] host_data_lines_out,
	output logic host_data_lines_oe_low,
	output logic int_out,
	// Serial and modem pins
	input wire logic serial_in,
	output logic serial_out,
	input wire logic cts_low,
	output logic rts_low,
	output logic dtr_low
);
	logic rd_act_ff, wr_act_ff, wr_act, rd_start, wr_done;
	asc_pkg::asc_req_t wreq_ff;
	logic [1:0] bank_ff;
	logic [4:0] widx, ridx, wsel;
	logic [7:0] cfg [32];
	logic [7:0] div_ff [4];
	logic [7:0] rdata, gir, lc, fm;
	logic [2:0] tx_flags_ff;
	logic latch, wdiv, rdiv;
	logic push [2], pop [2], flush [2];
	logic [10:0] fin [2], fout [2];
	logic [2:0] fcnt [2];
	logic full [2];
	logic tick [2];
	logic [3:0] rs_ff;
	logic [3:0] rs_set;
	logic cts_ff, dcts_ff, dcts_clr;
	logic [3:0] src;

	assign wr_act = ~chip_select_low & ~write_strobe_low;
	assign rd_start = ~chip_select_low & ~read_strobe_low & ~rd_act_ff;
	// Commit at the trailing edge so data setup up to strobe release holds
	assign wr_done = wr_act_ff & ~wr_act;
	assign widx = {bank_ff, wreq_ff.addr};
	assign ridx = {bank_ff, register_address_lines};
	assign lc = cfg[asc_pkg::IDX_LINE_CTL];
	assign fm = cfg[asc_pkg::IDX_FIFO_MODE];
	assign latch = lc[asc_pkg::LC_LATCH];

	function automatic logic is_div(input logic [4:0] idx, input logic lb);
		is_div = lb & (idx[4:3] == 2'b00 || idx[4:3] == 2'b11) & (idx[2:1] == 2'b00);
	endfunction
	assign wdiv = is_div(widx, latch);
	assign rdiv = is_div(ridx, latch);
	// Modem control is also reachable, write only, from bank 01
	assign wsel = (widx == asc_pkg::IDX_LEVEL) ? asc_pkg::IDX_MDM_CTL : widx;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_act_ff <= 1'b0;
			wr_act_ff <= 1'b0;
			wreq_ff <= '0;
		end else begin
			rd_act_ff <= ~chip_select_low & ~read_strobe_low;
			wr_act_ff <= wr_act;
			if (wr_act) begin
				wreq_ff <= {register_address_lines, host_data_lines_in};
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bank_ff <= 2'b00;
			tx_flags_ff <= 3'h0;
		end else if (wr_done) begin
			if (wreq_ff.addr == asc_pkg::ADDR_BANK) begin
				bank_ff <= wreq_ff.data[asc_pkg::BANK_POS +: 2];
			end
			if (widx == asc_pkg::IDX_CHFLAG) begin
				tx_flags_ff <= wreq_ff.data[2:0];
			end
		end
	end

	// Stored settings; status, data and command addresses hold nothing here
	for (genvar i = 0; i < 32; i++) begin : g_cfg
		if (asc_pkg::cfg_kept(5'(i))) begin : g_kept
			logic [7:0] q_ff;
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					q_ff <= asc_pkg::cfg_reset(5'(i));
				end else if (wr_done && !wdiv && wsel == 5'(i)
						&& wreq_ff.addr != asc_pkg::ADDR_BANK) begin
					q_ff <= wreq_ff.data;
				end
			end
			assign cfg[i] = q_ff;
		end else begin : g_none
			assign cfg[i] = 8'h00;
		end
	end

	// Divisors: 0/1 = A low/high in bank 00, 2/3 = B low/high in bank 11
	for (genvar i = 0; i < 4; i++) begin : g_div
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				div_ff[i] <= (i == 0) ? asc_pkg::RV_DIV_A_LO :
					(i == 2) ? asc_pkg::RV_DIV_B_LO : asc_pkg::RV_ZERO;
			end else if (wr_done && wdiv && {widx[4], widx[0]} == 2'(i)) begin
				div_ff[i] <= wreq_ff.data;
			end
		end
	end

	// Baud generators give one 16x tick each time the divisor is counted out
	for (genvar g = 0; g < 2; g++) begin : g_baud
		logic [15:0] cnt_ff, lim;
		assign lim = ({div_ff[2*g+1], div_ff[2*g]} == 16'h0000) ? 16'h0000 :
			{div_ff[2*g+1], div_ff[2*g]} - 16'h0001;
		assign tick[g] = (cnt_ff >= lim);
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				cnt_ff <= 16'h0000;
			end else begin
				cnt_ff <= tick[g] ? 16'h0000 : cnt_ff + 16'h0001;
			end
		end
	end

	// Queue 0 sends, queue 1 receives; depth limits the count, not the pointers
	for (genvar c = 0; c < 2; c++) begin : g_fifo
		logic [10:0] mem [4];
		logic [1:0] wp_ff, rp_ff;
		logic [2:0] cnt_ff, depth;
		logic do_push, do_pop;
		assign depth = {1'b0, fm[2*c +: 2]} + 3'h1;
		assign full[c] = (cnt_ff >= depth);
		assign do_push = push[c] & ~full[c];
		assign do_pop = pop[c] & (cnt_ff != 3'h0);
		assign fout[c] = mem[rp_ff];
		assign fcnt[c] = cnt_ff;
		always_ff @(posedge core_clk) begin
			if (do_push) begin
				mem[wp_ff] <= fin[c];
			end
		end
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				wp_ff <= 2'b00;
				rp_ff <= 2'b00;
				cnt_ff <= 3'h0;
			end else if (flush[c]) begin
				wp_ff <= 2'b00;
				rp_ff <= 2'b00;
				cnt_ff <= 3'h0;
			end else begin
				wp_ff <= wp_ff + {1'b0, do_push};
				rp_ff <= rp_ff + {1'b0, do_pop};
				cnt_ff <= cnt_ff + {2'b00, do_push} - {2'b00, do_pop};
			end
		end
	end

	// Host side of the queues and the command strobes
	assign push[0] = wr_done && ((widx == asc_pkg::IDX_DATA0 && !wdiv)
		|| widx == asc_pkg::IDX_DATA1);
	assign fin[0] = {tx_flags_ff, wreq_ff.data};
	assign pop[1] = rd_start && ((ridx == asc_pkg::IDX_DATA0 && !rdiv)
		|| ridx == asc_pkg::IDX_DATA1);
	assign flush[0] = wr_done && wreq_ff.data[asc_pkg::CMD_FLUSH]
		&& (widx == asc_pkg::IDX_TX_CMD || widx == asc_pkg::IDX_INT_CMD);
	assign flush[1] = wr_done && wreq_ff.data[asc_pkg::CMD_FLUSH]
		&& (widx == asc_pkg::IDX_RX_CMD || widx == asc_pkg::IDX_INT_CMD);

	// Frame format shared by both engines
	logic [3:0] nb, nd, flen;
	logic [7:0] dmask;
	logic pen, podd;
	assign nb = 4'h5 + {2'b00, lc[asc_pkg::LC_LEN +: 2]};
	assign pen = lc[asc_pkg::LC_PAR_EN];
	assign podd = ~lc[asc_pkg::LC_PAR_EVEN];
	assign nd = nb + {3'b000, pen};
	assign flen = nd + 4'h1 + {3'b000, lc[asc_pkg::LC_STOP]};
	assign dmask = 8'hff >> (4'h8 - nb);

	function automatic logic [11:0] frame_of(input logic [7:0] d, input logic [3:0] n,
			input logic pe, input logic p);
		logic [11:0] f;
		f = 12'hfff;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(n)) f[i+1] = d[i];
		end
		if (pe) f[n+1] = p;
		return f;
	endfunction

	// Transmit engine
	asc_pkg::asc_tx_t tx_st_ff;
	logic [11:0] sh_ff;
	logic [3:0] tbit_ff, tsub_ff;
	logic tx_tick, txd_ff, tx_go;
	logic [7:0] tdat;
	assign tx_tick = cfg[asc_pkg::IDX_CLK_SRC][asc_pkg::CK_TXB] ? tick[1] : tick[0];
	// Waiting for clear-to-send holds the queue, so back-pressure reaches the host
	assign tx_go = (fcnt[0] != 3'h0) && (!cfg[asc_pkg::IDX_TX_MODE][asc_pkg::TM_FLOW]
		|| !cts_low);
	assign pop[0] = (tx_st_ff == asc_pkg::TX_IDLE) && tx_go;
	assign tdat = fout[0][7:0] & dmask;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_st_ff <= asc_pkg::TX_IDLE;
			sh_ff <= 12'hfff;
			tbit_ff <= 4'h0;
			tsub_ff <= 4'h0;
			txd_ff <= 1'b1;
		end else begin
			case (tx_st_ff)
				asc_pkg::TX_IDLE: begin
					if (tx_go) begin
						sh_ff <= frame_of(tdat, nb, pen, ^tdat ^ podd);
						tbit_ff <= flen;
						tsub_ff <= 4'h0;
						txd_ff <= 1'b0;
						tx_st_ff <= asc_pkg::TX_SEND;
					end
				end
				asc_pkg::TX_SEND: begin
					if (tx_tick) begin
						tsub_ff <= tsub_ff + 4'h1;
						if (tsub_ff == 4'hf) begin
							if (tbit_ff == 4'h0) begin
								txd_ff <= 1'b1;
								tx_st_ff <= asc_pkg::TX_IDLE;
							end else begin
								sh_ff <= {1'b1, sh_ff[11:1]};
								txd_ff <= sh_ff[1];
								tbit_ff <= tbit_ff - 4'h1;
							end
						end
					end
				end
				default: tx_st_ff <= asc_pkg::TX_IDLE;
			endcase
		end
	end

	// Receive engine, mid-bit sampling on the 16x tick
	asc_pkg::asc_rx_t rx_st_ff;
	logic [8:0] rsh_ff, algn;
	logic [3:0] rbit_ff, rsub_ff;
	logic rx_tick, rx_in, rx_done, perr, accept, ctrl;
	logic [7:0] rdat, m0, m1;
	assign rx_tick = cfg[asc_pkg::IDX_CLK_SRC][asc_pkg::CK_RXB] ? tick[1] : tick[0];
	assign rx_in = cfg[asc_pkg::IDX_MDM_CTL][asc_pkg::MC_LOOP] ? txd_ff : serial_in;
	assign algn = rsh_ff >> (4'h9 - nd);
	assign rdat = algn[7:0] & dmask;
	assign perr = pen & (algn[nb] != (^rdat ^ podd));
	assign m0 = cfg[asc_pkg::IDX_MATCH0];
	assign m1 = cfg[asc_pkg::IDX_MATCH1];
	assign accept = !cfg[asc_pkg::IDX_RX_MODE][asc_pkg::RM_ADDR]
		|| rdat == m0 || rdat == m1;
	assign ctrl = cfg[asc_pkg::IDX_RX_MODE][asc_pkg::RM_CTRL] && rdat == m0;
	assign rx_done = (rx_st_ff == asc_pkg::RX_STOP) && rx_tick && rsub_ff == 4'hf;
	assign push[1] = rx_done && accept;
	assign fin[1] = {perr, !rx_in, ctrl, rdat};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_ff <= asc_pkg::RX_IDLE;
			rsh_ff <= 9'h000;
			rbit_ff <= 4'h0;
			rsub_ff <= 4'h0;
		end else begin
			case (rx_st_ff)
				asc_pkg::RX_IDLE: begin
					rsub_ff <= 4'h0;
					if (!rx_in) rx_st_ff <= asc_pkg::RX_START;
				end
				asc_pkg::RX_START: begin
					if (rx_tick) begin
						rsub_ff <= rsub_ff + 4'h1;
						if (rsub_ff == 4'h7) begin
							// A start bit gone high by mid-bit is a glitch
							rx_st_ff <= rx_in ? asc_pkg::RX_IDLE : asc_pkg::RX_DATA;
							rsub_ff <= 4'h0;
							rbit_ff <= 4'h0;
						end
					end
				end
				asc_pkg::RX_DATA: begin
					if (rx_tick) begin
						rsub_ff <= rsub_ff + 4'h1;
						if (rsub_ff == 4'hf) begin
							rsh_ff <= {rx_in, rsh_ff[8:1]};
							rbit_ff <= rbit_ff + 4'h1;
							if (rbit_ff == nd - 4'h1) rx_st_ff <= asc_pkg::RX_STOP;
						end
					end
				end
				asc_pkg::RX_STOP: begin
					if (rx_tick) begin
						rsub_ff <= rsub_ff + 4'h1;
						if (rsub_ff == 4'hf) rx_st_ff <= asc_pkg::RX_IDLE;
					end
				end
				default: rx_st_ff <= asc_pkg::RX_IDLE;
			endcase
		end
	end

	// Sticky receive status: 0 control char, 1 framing, 2 parity, 3 overrun
	assign rs_set = {rx_done & accept & full[1], rx_done & perr, rx_done & !rx_in,
		push[1] & ctrl};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rs_ff <= 4'h0;
		end else if (rd_start && ridx == asc_pkg::IDX_RX_CMD) begin
			rs_ff <= rs_set; // Set wins over the read clear
		end else begin
			rs_ff <= rs_ff | rs_set;
		end
	end

	assign dcts_clr = (rd_start && (ridx == asc_pkg::IDX_MDM_ST || ridx == asc_pkg::IDX_TX_CMD))
		|| (wr_done && widx == asc_pkg::IDX_MDM_ST);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cts_ff <= 1'b0;
			dcts_ff <= 1'b0;
		end else begin
			cts_ff <= ~cts_low;
			dcts_ff <= (~cts_low != cts_ff) | (dcts_ff & ~dcts_clr);
		end
	end

	// Priority line, receive, transmit, modem
	assign src = {dcts_ff & cfg[asc_pkg::IDX_GEN_EN][asc_pkg::GE_MDM],
		(fcnt[0] == 3'h0) & cfg[asc_pkg::IDX_GEN_EN][asc_pkg::GE_TX],
		(fcnt[1] != 3'h0) & cfg[asc_pkg::IDX_GEN_EN][asc_pkg::GE_RX],
		(|rs_ff[3:1]) & cfg[asc_pkg::IDX_GEN_EN][asc_pkg::GE_LINE]};
	always_comb begin
		gir = 8'h00;
		gir[asc_pkg::GI_NONE] = ~|src;
		gir[asc_pkg::GI_SRC +: 2] = src[0] ? 2'd0 : src[1] ? 2'd1 : src[2] ? 2'd2 : 2'd3;
		if (~|src) gir[asc_pkg::GI_SRC +: 2] = 2'd0;
		gir[asc_pkg::BANK_POS +: 2] = bank_ff;
	end

	// Read decode; bank 00 alone matches the older single-bank layout
	always_comb begin
		rdata = cfg[ridx];
		if (register_address_lines == asc_pkg::ADDR_BANK) begin
			rdata = gir;
		end else if (rdiv) begin
			rdata = div_ff[{ridx[4], ridx[0]}];
		end else begin
			case (ridx)
				asc_pkg::IDX_DATA0, asc_pkg::IDX_DATA1: rdata = fout[1][7:0];
				asc_pkg::IDX_CHFLAG: rdata = {5'h00, fout[1][10:8]};
				asc_pkg::IDX_LINE_ST: begin
					rdata = 8'h00;
					rdata[asc_pkg::LS_RX_RDY] = (fcnt[1] != 3'h0);
					rdata[asc_pkg::LS_OVR] = rs_ff[3];
					rdata[asc_pkg::LS_PERR] = rs_ff[2];
					rdata[asc_pkg::LS_FERR] = rs_ff[1];
					rdata[asc_pkg::LS_TX_EMPTY] = (fcnt[0] == 3'h0);
					rdata[asc_pkg::LS_TX_IDLE] = (tx_st_ff == asc_pkg::TX_IDLE);
				end
				asc_pkg::IDX_MDM_ST, asc_pkg::IDX_TX_CMD: begin
					rdata = 8'h00;
					rdata[asc_pkg::MS_DCTS] = dcts_ff;
					rdata[asc_pkg::MS_CTS] = cts_ff;
				end
				asc_pkg::IDX_TIMER: rdata = asc_pkg::TIMER_ST_RV;
				asc_pkg::IDX_LEVEL: begin
					rdata = 8'h00;
					rdata[asc_pkg::FL_TX +: 3] = fcnt[0];
					rdata[asc_pkg::FL_RX +: 3] = fcnt[1];
				end
				asc_pkg::IDX_RX_CMD: rdata = {4'h0, rs_ff};
				asc_pkg::IDX_INT_CMD: begin
					rdata = 8'h00;
					rdata[asc_pkg::GS_RX] = (fcnt[1] != 3'h0);
					rdata[asc_pkg::GS_TX_ROOM] = ~full[0];
					rdata[asc_pkg::GS_TX_IDLE] = (tx_st_ff == asc_pkg::TX_IDLE);
				end
				default: rdata = cfg[ridx];
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			host_data_lines_out <= 8'h00;
			host_data_lines_oe_low <= 1'b1;
			int_out <= 1'b0;
			serial_out <= 1'b1;
			rts_low <= 1'b1;
			dtr_low <= 1'b1;
		end else begin
			if (rd_start) host_data_lines_out <= rdata;
			host_data_lines_oe_low <= chip_select_low | read_strobe_low;
			int_out <= |src;
			serial_out <= txd_ff;
			rts_low <= ~cfg[asc_pkg::IDX_MDM_CTL][asc_pkg::MC_RTS];
			dtr_low <= ~cfg[asc_pkg::IDX_MDM_CTL][asc_pkg::MC_DTR];
		end
	end
endmodule

// >>> asc_checker.sv
`timescale 1ns/100ps
module asc_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Host port
	input wire logic chip_select_low,
	input wire logic read_strobe_low,
	input wire logic write_strobe_low,
	input wire logic [7:0] host_data_lines_out,
	input wire logic host_data_lines_oe_low,
	// Serial and modem pins
	input wire logic serial_out,
	input wire logic rts_low,
	input wire logic dtr_low
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence rd_low;
		!chip_select_low && !read_strobe_low;
	endsequence
	sequence wr_low;
		!chip_select_low && !write_strobe_low;
	endsequence
	sequence rd_held;
		rd_low ##1 rd_low;
	endsequence
	write_quiet_a: assert property (wr_low |-> host_data_lines_oe_low)
		else $error("data bus driven during a write");
	oe_drive_a: assert property (rd_low |=> !host_data_lines_oe_low)
		else $error("bus not driven after read strobe");
	oe_release_a: assert property ((chip_select_low || read_strobe_low) |=>
		host_data_lines_oe_low)
		else $error("bus driven without a read");
	rd_hold_a: assert property (rd_held |=> $stable(host_data_lines_out))
		else $error("read data moved during a read");
	data_keep_a: assert property ($changed(host_data_lines_out) |->
		!$past(chip_select_low) && !$past(read_strobe_low))
		else $error("read data changed without a read start");
	start_bit_a: assert property ($fell(serial_out) |=> !serial_out [*8])
		else $error("start bit too short");
	// Strobes seen low at the last latching edge, commit one edge on, pin one edge later
	rts_cause_a: assert property ($changed(rts_low) |->
		!$past(chip_select_low, 3) && !$past(write_strobe_low, 3))
		else $error("rts moved without a write");
	dtr_cause_a: assert property ($changed(dtr_low) |->
		!$past(chip_select_low, 3) && !$past(write_strobe_low, 3))
		else $error("dtr moved without a write");
endmodule

// >>> asc_host.sv
`timescale 1ns/100ps
module asc_host (
	// Clock
	input wire logic core_clk,
	// Host port
	output logic chip_select_low,
	output logic read_strobe_low,
	output logic write_strobe_low,
	output logic [2:0] register_address_lines,
	output logic [7:0] host_data_lines_in,
	input wire logic [7:0] host_data_lines_out,
	input wire logic host_data_lines_oe_low
);
	logic [7:0] drv = 8'h00;
	// Bus level: the device wins while it drives, else whatever the host left
	assign host_data_lines_in = host_data_lines_oe_low ? drv : host_data_lines_out;
	initial begin
		chip_select_low = 1'b1;
		read_strobe_low = 1'b1;
		write_strobe_low = 1'b1;
		register_address_lines = 3'h0;
	end
	// One strobe at a time, held over two edges, then idle for the gap
	task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge core_clk);
		chip_select_low = 1'b0;
		register_address_lines = a;
		drv = d;
		write_strobe_low = !w;
		read_strobe_low = w;
		repeat (2) @(negedge core_clk);
		q = host_data_lines_oe_low ? ~host_data_lines_out : host_data_lines_out;
		chip_select_low = 1'b1;
		read_strobe_low = 1'b1;
		write_strobe_low = 1'b1;
		// Released bus must not keep looking like valid data
		drv = ~d;
		@(negedge core_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] q);
		access(1'b0, a, 8'h00, q);
	endtask
	task automatic bank(input logic [1:0] b);
		wr(3'h2, {1'b0, b, 5'h00});
	endtask
endmodule

// >>> async_serial_controller_test.sv
`timescale 1ns/100ps
module async_serial_controller_test;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	// Idle is high: clear-to-send not yet given
	logic cts_low = 1'b1;
	logic chip_select_low, read_strobe_low, write_strobe_low, host_data_lines_oe_low;
	logic int_out, serial_out, rts_low, dtr_low;
	logic [2:0] register_address_lines;
	logic [7:0] host_data_lines_in, host_data_lines_out, q;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	// {bank, address, reset value} of every stored register and of six status registers
	logic [12:0] rv [22] = '{13'h0300, 13'h0560, 13'h0400, 13'h0600, 13'h0700, 13'h0100,
		13'h0f12, 13'h0b30, 13'h0c00, 13'h0d00, 13'h140c, 13'h161e, 13'h1100, 13'h1300,
		13'h1500, 13'h1700, 13'h1b84, 13'h1cfc, 13'h1d0f, 13'h1800, 13'h1904, 13'h1e00};
	always #5 core_clk = ~core_clk;
	asc_top uut (.core_clk(core_clk), .nrst(nrst), .chip_select_low(chip_select_low),
		.read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
		.register_address_lines(register_address_lines), .host_data_lines_in(host_data_lines_in),
		.host_data_lines_out(host_data_lines_out), .host_data_lines_oe_low(host_data_lines_oe_low),
		.int_out(int_out), .serial_in(serial_out), .serial_out(serial_out),
		.cts_low(cts_low), .rts_low(rts_low), .dtr_low(dtr_low));
	asc_host host (.core_clk(core_clk), .chip_select_low(chip_select_low),
		.read_strobe_low(read_strobe_low), .write_strobe_low(write_strobe_low),
		.register_address_lines(register_address_lines), .host_data_lines_in(host_data_lines_in),
		.host_data_lines_out(host_data_lines_out), .host_data_lines_oe_low(host_data_lines_oe_low));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic t_reset();
		check("idle pins", 8'h0e, {4'h0, rts_low, dtr_low, serial_out, int_out});
		foreach (rv[i]) begin
			host.bank(rv[i][12:11]);
			host.rd(3'h2, q);
			check("bank readback", {1'b0, rv[i][12:11], 5'h01}, q);
			host.rd(rv[i][10:8], q);
			check("reset value", rv[i][7:0], q);
		end
	endtask
	task automatic t_latch();
		host.bank(2'h0);
		host.wr(3'h3, 8'h80);
		host.rd(3'h0, q);
		check("divisor a low", 8'h02, q);
		host.rd(3'h1, q);
		check("divisor a high", 8'h00, q);
		host.bank(2'h3);
		host.rd(3'h0, q);
		check("divisor b low", 8'h05, q);
		host.wr(3'h1, 8'h5a);
		host.rd(3'h1, q);
		check("divisor b high", 8'h5a, q);
		host.bank(2'h0);
		host.wr(3'h3, 8'h03);
		host.rd(3'h1, q);
		check("general enable", 8'h00, q);
		host.bank(2'h3);
		host.rd(3'h0, q);
		check("clock source", 8'h00, q);
		host.rd(3'h1, q);
		check("baud a config", 8'h04, q);
	endtask
	task automatic t_modem();
		host.bank(2'h1);
		host.wr(3'h4, 8'h03);
		host.wr(3'h3, 8'hff);
		host.rd(3'h4, q);
		check("level not control", 8'h00, q);
		host.rd(3'h3, q);
		check("timer status", 8'h30, q);
		check("modem pins", 8'h00, {6'h0, rts_low, dtr_low});
		host.bank(2'h0);
		host.rd(3'h4, q);
		check("modem control", 8'h03, q);
	endtask
	task automatic t_serial();
		logic [9:0] frame;
		frame = {1'b1, 8'ha5, 1'b0};
		host.wr(3'h1, 8'h01);
		host.bank(2'h1);
		host.wr(3'h0, 8'ha5);
		for (int i = 0; i < 200 && serial_out === 1'b1; i++) @(negedge core_clk);
		// Divisor 2 gives 32 cycles a bit; start near mid-bit
		repeat (16) @(negedge core_clk);
		for (int k = 0; k < 10; k++) begin
			check("line bit", {7'h0, frame[k]}, {7'h0, serial_out});
			repeat (32) @(negedge core_clk);
		end
		for (int i = 0; i < 100 && int_out !== 1'b1; i++) @(negedge core_clk);
		check("interrupt up", 8'h01, {7'h0, int_out});
		host.rd(3'h2, q);
		check("interrupt source", 8'h22, q);
		host.rd(3'h0, q);
		check("received char", 8'ha5, q);
		check("interrupt down", 8'h00, {7'h0, int_out});
	endtask
	task automatic t_flow();
		host.rd(3'h6, q);
		check("modem status idle", 8'h00, q);
		@(negedge core_clk) cts_low = ~cts_low;
		repeat (2) @(negedge core_clk);
		host.rd(3'h6, q);
		check("cts change", 8'h11, q);
		host.rd(3'h6, q);
		check("cts change cleared", 8'h10, q);
		host.bank(2'h2);
		host.wr(3'h3, 8'h01);
		@(negedge core_clk) cts_low = ~cts_low;
		host.bank(2'h1);
		host.wr(3'h0, 8'h3c);
		host.rd(3'h4, q);
		check("held in queue", 8'h01, q);
		host.rd(3'h7, q);
		check("queue full", 8'h10, q);
		check("line held", 8'h01, {7'h0, serial_out});
		@(negedge core_clk) cts_low = ~cts_low;
		for (int i = 0; i < 200 && serial_out === 1'b1; i++) @(negedge core_clk);
		check("line started", 8'h00, {7'h0, serial_out});
		repeat (400) @(negedge core_clk);
		host.rd(3'h0, q);
		check("second char", 8'h3c, q);
		host.rd(3'h4, q);
		check("queues drained", 8'h00, q);
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		nrst = 1'b1;
		t_reset();
		t_latch();
		t_modem();
		t_serial();
		t_flow();
		test_done();
	end
endmodule
bind asc_top asc_checker chk (.core_clk(core_clk), .nrst(nrst),
	.chip_select_low(chip_select_low), .read_strobe_low(read_strobe_low),
	.write_strobe_low(write_strobe_low), .host_data_lines_out(host_data_lines_out),
	.host_data_lines_oe_low(host_data_lines_oe_low), .serial_out(serial_out),
	.rts_low(rts_low), .dtr_low(dtr_low));
